// ---- design/mode_arbiter_regs.svh ----
`ifndef MODE_ARBITER_REGS_SVH
`define MODE_ARBITER_REGS_SVH

// Reset values of the configuration held inside the arbiter
`define CFG_ASSIGN_NONE   4'h0
`define CFG_UFKEY_RST     2'h0
`define CFG_FLAG_RST      1'b0

// Reset values of the operating state
`define RUN_RST           1'b0
`define REMOTE_RST        1'b0

// Zero-current output code used by the shutdown low setting
`define OUT_ZERO_CODE     16'h0000

// Synchroniser depth on contact pins
`define SYNC_STAGES       2

`endif

// ---- design/mode_arbiter_pkg.sv ----
package mode_arbiter_pkg;

  // Operation display selection, one-hot
  typedef enum logic [2:0] {
    VIEW_STOP = 3'b001,
    VIEW_SP   = 3'b010,
    VIEW_OUT  = 3'b100
  } view_t;

  // Function given to the user function key
  typedef enum logic [1:0] {
    UF_NONE      = 2'h0,
    UF_STOP_RUN  = 2'h1,
    UF_REM_LCL   = 2'h2,
    UF_LATCH     = 2'h3
  } ufkey_func_t;

  // Manual output method
  typedef enum logic {
    direct_key_method  = 1'b0,
    confirm_key_method = 1'b1
  } manual_output_method_t;

  // One mode request from one source
  typedef struct packed {
    logic valid;
    logic value;
  } mode_req_t;

  // Configuration loaded as one word
  typedef struct packed {
    logic [3:0]            stop_run_assign;
    logic                  stop_run_edge;
    logic [3:0]            rem_lcl_assign;
    logic                  rem_lcl_edge;
    logic                  latch_on_contact;
    ufkey_func_t           ufkey_func;
    manual_output_method_t manual_output_method;
    logic                  control_type_onoff;
    logic                  limiter_en;
    logic                  shutdown_low_setting;
    logic                  current_loop;
    logic                  sp_track;
  } cfg_t;

endpackage

// ---- design/contact_conditioner.sv ----
`timescale 1ns/1ps
`default_nettype none

module contact_conditioner (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Contact pin
  input  wire logic contact_pin,
  // Conditioned contact
  output logic      level,
  output logic      rise
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Two-stage synchroniser and edge history
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= contact_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Level and rising edge after synchronisation
  assign level = sync2_reg;
  assign rise  = sync2_reg & ~prev_reg;

  AST_CONTACT_LATENCY: assert property (@(posedge mclk) disable iff (srst)
    !$past(srst, 2) |-> level == $past(contact_pin, 2))
    else $error("contact level not two cycles behind pin");

endmodule

`default_nettype wire

// ---- design/manual_output_adjuster.sv ----
`timescale 1ns/1ps
`default_nettype none

module manual_output_adjuster #(
  parameter int OUT_W = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // Mode
  input  wire logic             enable,
  input  wire logic             load,
  input  wire logic [OUT_W-1:0] load_value,
  input  wire logic             confirm_mode,
  // Keys and link
  input  wire logic             key_up,
  input  wire logic             key_down,
  input  wire logic             confirm_key,
  input  wire logic             comm_wr,
  input  wire logic [OUT_W-1:0] comm_value,
  // Bounds and step
  input  wire logic [OUT_W-1:0] lo_bound,
  input  wire logic [OUT_W-1:0] hi_bound,
  input  wire logic [OUT_W-1:0] step,
  // Result
  output logic [OUT_W-1:0]      value_reg,
  output logic [OUT_W-1:0]      pending_reg
);

  logic [OUT_W-1:0] base;
  logic [OUT_W:0]   up_sum;
  logic [OUT_W:0]   dn_diff;
  logic [OUT_W-1:0] adj;
  logic [OUT_W-1:0] comm_clamped;
  logic [OUT_W-1:0] pend_clamped;
  logic             key_act;

  // Saturating step within the active bounds
  assign base    = confirm_mode ? pending_reg : value_reg;
  assign up_sum  = {1'b0, base} + {1'b0, step};
  assign dn_diff = {1'b0, base} - {1'b0, step};
  assign adj = key_up ? ((up_sum > {1'b0, hi_bound}) ? hi_bound : up_sum[OUT_W-1:0])
             : ((dn_diff[OUT_W] || dn_diff[OUT_W-1:0] < lo_bound) ? lo_bound : dn_diff[OUT_W-1:0]);
  assign key_act = enable & (key_up ^ key_down);
  assign comm_clamped = (comm_value > hi_bound) ? hi_bound : (comm_value < lo_bound) ? lo_bound : comm_value;
  assign pend_clamped = (pending_reg > hi_bound) ? hi_bound : (pending_reg < lo_bound) ? lo_bound : pending_reg;

  // Output and pending value; load beats link beats keys
  always_ff @(posedge mclk) begin
    if (srst) begin
      value_reg   <= '0;
      pending_reg <= '0;
    end else if (load) begin
      value_reg   <= load_value;
      pending_reg <= load_value;
    end else if (enable && comm_wr) begin
      value_reg   <= comm_clamped;
      pending_reg <= comm_clamped;
    end else if (key_act && !confirm_mode) begin
      value_reg   <= adj;
      pending_reg <= adj;
    end else if (key_act) begin
      pending_reg <= adj;
    end else if (enable && confirm_mode && confirm_key) begin
      value_reg   <= pend_clamped;
    end
  end

  AST_NO_CHANGE_STOPPED: assert property (@(posedge mclk) disable iff (srst)
    !enable && !load |=> $stable(value_reg) && $stable(pending_reg))
    else $error("manual output changed while disabled");

  AST_DIRECT_UP: assert property (@(posedge mclk) disable iff (srst)
    enable && !load && !comm_wr && !confirm_mode && key_up && !key_down && up_sum <= {1'b0, hi_bound}
    |=> value_reg == $past(value_reg) + $past(step))
    else $error("direct up key did not raise output by one step");

  AST_CONFIRM_HOLD: assert property (@(posedge mclk) disable iff (srst)
    enable && confirm_mode && !load && !comm_wr && !confirm_key |=> $stable(value_reg))
    else $error("confirm method changed output without confirm key");

  AST_CONFIRM_APPLY: assert property (@(posedge mclk) disable iff (srst)
    enable && confirm_mode && !load && !comm_wr && !key_act && confirm_key |=> value_reg == $past(pend_clamped))
    else $error("confirm key did not apply pending value");

  AST_BOUNDS: assert property (@(posedge mclk) disable iff (srst)
    key_act && !load && !comm_wr && lo_bound <= hi_bound |=> pending_reg <= $past(hi_bound) && pending_reg >= $past(lo_bound))
    else $error("manual value left the limiter bounds");

endmodule

`default_nettype wire

// ---- design/operating_mode_switch_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mode_arbiter_regs.svh"

module operating_mode_switch_arbiter #(
  parameter int              OUT_W        = 16,
  parameter int              ALARM_N      = 4,
  parameter int              PID_W        = 3,
  parameter logic [15:0]     OUT_LIVE_MIN = 16'h0333,
  parameter logic [15:0]     OUT_FULL     = 16'hFFFF
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         srst,
  // Configuration load
  input  wire logic                         cfg_load,
  input  wire mode_arbiter_pkg::cfg_t       cfg_in,
  // Contact pins
  input  wire logic                         stop_run_contact,
  input  wire logic                         rem_lcl_contact,
  input  wire logic                         latch_contact,
  // Stop/run requests, value 1 means run
  input  wire mode_arbiter_pkg::mode_req_t  sr_param,
  input  wire mode_arbiter_pkg::mode_req_t  sr_comm,
  input  wire mode_arbiter_pkg::mode_req_t  sr_key,
  // Remote/local requests, value 1 means remote
  input  wire mode_arbiter_pkg::mode_req_t  rl_param,
  input  wire mode_arbiter_pkg::mode_req_t  rl_comm,
  input  wire mode_arbiter_pkg::mode_req_t  rl_key,
  // Keys
  input  wire logic                         ufkey_press,
  input  wire logic                         key_up,
  input  wire logic                         key_down,
  input  wire logic                         confirm_key,
  // Link output write and latch release
  input  wire logic                         comm_out_wr,
  input  wire logic [OUT_W-1:0]             comm_out_value,
  input  wire logic                         comm_latch_release,
  // Loop values
  input  wire logic                         manual_mode,
  input  wire logic [OUT_W-1:0]             auto_out,
  input  wire logic [OUT_W-1:0]             preset_out,
  input  wire logic [OUT_W-1:0]             output_high_limit,
  input  wire logic [OUT_W-1:0]             output_low_limit,
  input  wire logic [OUT_W-1:0]             manual_step,
  input  wire logic [OUT_W-1:0]             remote_sp,
  input  wire logic                         local_sp_wr,
  input  wire logic [OUT_W-1:0]             local_sp_wdata,
  input  wire logic [PID_W-1:0]             pid_group_in,
  // Alarms
  input  wire logic [ALARM_N-1:0]           alarm_raw,
  // Results
  output logic [OUT_W-1:0]                  ctl_out_reg,
  output logic [OUT_W-1:0]                  pending_out,
  output logic [OUT_W-1:0]                  active_sp_reg,
  output logic [OUT_W-1:0]                  local_sp_reg,
  output logic [PID_W-1:0]                  pid_group_reg,
  output logic                              alg_track,
  output mode_arbiter_pkg::view_t           view_reg,
  output logic [ALARM_N-1:0]                alarm_latch_reg,
  // Lamps
  output logic                              stop_lamp,
  output logic                              remote_lamp
);

  mode_arbiter_pkg::cfg_t  cfg_reg;
  mode_arbiter_pkg::view_t view_next;
  logic             run_reg;
  logic             run_next;
  logic             remote_reg;
  logic             remote_next;
  logic             sr_level;
  logic             sr_rise;
  logic             rl_level;
  logic             rl_rise;
  logic             lr_level;
  logic             lr_rise;
  logic             sr_assigned;
  logic             sr_lvl_on;
  logic             sr_edge_hit;
  logic             uf_sr;
  logic             rl_assigned;
  logic             rl_lvl_on;
  logic             rl_edge_hit;
  logic             uf_rl;
  logic             release_pulse;
  logic             to_local;
  logic             confirm_mode;
  logic             man_enable;
  logic             man_load;
  logic [OUT_W-1:0] man_value;
  logic [OUT_W-1:0] lo_bound;
  logic [OUT_W-1:0] hi_bound;
  logic [OUT_W-1:0] local_sp_next;

  // Configuration, unassigned after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_reg <= '{stop_run_assign: `CFG_ASSIGN_NONE, rem_lcl_assign: `CFG_ASSIGN_NONE,
                   ufkey_func: mode_arbiter_pkg::ufkey_func_t'(`CFG_UFKEY_RST),
                   manual_output_method: mode_arbiter_pkg::direct_key_method,
                   default: `CFG_FLAG_RST};
    end else if (cfg_load) begin
      cfg_reg <= cfg_in;
    end
  end

  // Contact pin conditioning
  contact_conditioner u_sr_contact (
    .mclk        (mclk),
    .srst        (srst),
    .contact_pin (stop_run_contact),
    .level       (sr_level),
    .rise        (sr_rise)
  );

  contact_conditioner u_rl_contact (
    .mclk        (mclk),
    .srst        (srst),
    .contact_pin (rem_lcl_contact),
    .level       (rl_level),
    .rise        (rl_rise)
  );

  contact_conditioner u_lr_contact (
    .mclk        (mclk),
    .srst        (srst),
    .contact_pin (latch_contact),
    .level       (lr_level),
    .rise        (lr_rise)
  );

  assign sr_assigned = |cfg_reg.stop_run_assign;
  assign sr_lvl_on   = sr_assigned & ~cfg_reg.stop_run_edge & sr_level;
  assign sr_edge_hit = sr_assigned & cfg_reg.stop_run_edge & sr_rise;
  assign uf_sr       = ufkey_press & (cfg_reg.ufkey_func == mode_arbiter_pkg::UF_STOP_RUN);

  // Stop/run selection, key and link gated
  assign run_next = sr_lvl_on                      ? 1'b0 :
                    sr_edge_hit                    ? ~run_reg :
                    (sr_comm.valid & ~sr_assigned) ? sr_comm.value :
                    sr_param.valid                 ? sr_param.value :
                    (sr_key.valid & ~sr_assigned)  ? sr_key.value :
                    (uf_sr & ~sr_assigned)         ? ~run_reg :
                    run_reg;

  assign rl_assigned = |cfg_reg.rem_lcl_assign;
  assign rl_lvl_on   = rl_assigned & ~cfg_reg.rem_lcl_edge & rl_level;
  assign rl_edge_hit = rl_assigned & cfg_reg.rem_lcl_edge & rl_rise;
  assign uf_rl       = ufkey_press & (cfg_reg.ufkey_func == mode_arbiter_pkg::UF_REM_LCL);

  assign remote_next = rl_lvl_on      ? 1'b1 :
                       rl_edge_hit    ? ~remote_reg :
                       rl_comm.valid  ? rl_comm.value :
                       rl_param.valid ? rl_param.value :
                       rl_key.valid   ? rl_key.value :
                       uf_rl          ? ~remote_reg :
                       remote_reg;

  // Mode state
  always_ff @(posedge mclk) begin
    if (srst) begin
      run_reg    <= `RUN_RST;
      remote_reg <= `REMOTE_RST;
    end else begin
      run_reg    <= run_next;
      remote_reg <= remote_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pid_group_reg <= '0;
    end else if (!remote_next) begin
      pid_group_reg <= pid_group_in;
    end
  end

  // Setpoint handover between remote and local
  assign to_local      = remote_reg & ~remote_next;
  assign local_sp_next = (to_local && cfg_reg.sp_track) ? remote_sp :
                         local_sp_wr                    ? local_sp_wdata : local_sp_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      local_sp_reg  <= '0;
      active_sp_reg <= '0;
    end else begin
      local_sp_reg  <= local_sp_next;
      active_sp_reg <= remote_next ? remote_sp : local_sp_next;
    end
  end

  // Manual bounds from limiter and shutdown setting
  assign lo_bound = (cfg_reg.shutdown_low_setting && cfg_reg.current_loop) ? OUT_W'(`OUT_ZERO_CODE) :
                    cfg_reg.limiter_en ? output_low_limit : OUT_W'(OUT_LIVE_MIN);
  assign hi_bound = cfg_reg.limiter_en ? output_high_limit : OUT_W'(OUT_FULL);

  assign confirm_mode = (cfg_reg.manual_output_method == mode_arbiter_pkg::confirm_key_method) &
                        ~cfg_reg.control_type_onoff;

  // Manual edits only while running in manual
  assign man_enable = run_reg & manual_mode;
  assign man_load   = ~man_enable;

  manual_output_adjuster #(
    .OUT_W (OUT_W)
  ) u_manual (
    .mclk         (mclk),
    .srst         (srst),
    .enable       (man_enable),
    .load         (man_load),
    .load_value   (ctl_out_reg),
    .confirm_mode (confirm_mode),
    .key_up       (key_up),
    .key_down     (key_down),
    .confirm_key  (confirm_key),
    .comm_wr      (comm_out_wr),
    .comm_value   (comm_out_value),
    .lo_bound     (lo_bound),
    .hi_bound     (hi_bound),
    .step         (manual_step),
    .value_reg    (man_value),
    .pending_reg  (pending_out)
  );

  // Control output: preset when stopped, else manual or algorithm
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl_out_reg <= '0;
    end else begin
      ctl_out_reg <= !run_next ? preset_out : (manual_mode ? man_value : auto_out);
    end
  end

  // Algorithm tracks the held output while stopped
  assign alg_track = ~run_reg;

  // Display view on stop and restart
  assign view_next = !run_next   ? mode_arbiter_pkg::VIEW_STOP :
                     manual_mode ? mode_arbiter_pkg::VIEW_OUT : mode_arbiter_pkg::VIEW_SP;

  always_ff @(posedge mclk) begin
    if (srst) begin
      view_reg <= mode_arbiter_pkg::VIEW_STOP;
    end else begin
      view_reg <= view_next;
    end
  end

  assign release_pulse = (cfg_reg.latch_on_contact & lr_rise) | comm_latch_release |
                         (ufkey_press & (cfg_reg.ufkey_func == mode_arbiter_pkg::UF_LATCH));

  // Alarm latches, set wins over release
  genvar gi;
  generate
    for (gi = 0; gi < ALARM_N; gi++) begin : g_alarm
      always_ff @(posedge mclk) begin
        if (srst) begin
          alarm_latch_reg[gi] <= 1'b0;
        end else begin
          alarm_latch_reg[gi] <= alarm_raw[gi] | (alarm_latch_reg[gi] & ~release_pulse);
        end
      end
    end
  endgenerate

  assign stop_lamp   = ~run_reg;
  assign remote_lamp = remote_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_restart;
    !run_reg ##1 run_reg;
  endsequence

  AST_SR_KEY_IGNORED: assert property (
    sr_assigned && !sr_lvl_on && !sr_edge_hit && !sr_param.valid |=> run_reg == $past(run_reg))
    else $error("key or link changed stop/run while contact assigned");

  AST_STOP_PRESET: assert property (
    run_reg && !run_next |=> ctl_out_reg == $past(preset_out) && view_reg == mode_arbiter_pkg::VIEW_STOP)
    else $error("stop did not step output to preset");

  AST_RESTART_VIEW: assert property (
    s_restart |-> view_reg == ($past(manual_mode) ? mode_arbiter_pkg::VIEW_OUT : mode_arbiter_pkg::VIEW_SP))
    else $error("wrong view at restart");

  AST_RL_LEVEL_FORCE: assert property (
    rl_lvl_on |=> remote_reg)
    else $error("level contact did not hold remote");

  AST_PID_FROZEN: assert property (
    remote_reg && remote_next |=> $stable(pid_group_reg))
    else $error("tuning group changed while remote");

  AST_REMOTE_SP: assert property (
    remote_next |=> active_sp_reg == $past(remote_sp))
    else $error("remote setpoint not applied");

  AST_TRACK_COPY: assert property (
    to_local && cfg_reg.sp_track |=> local_sp_reg == $past(remote_sp) && active_sp_reg == $past(remote_sp))
    else $error("tracking did not copy remote setpoint");

  AST_LATCH_CLEAR: assert property (
    release_pulse && alarm_raw == '0 |=> alarm_latch_reg == '0)
    else $error("release left a latched alarm");

  AST_PRIORITY: assert property (
    !rl_lvl_on && !rl_edge_hit && rl_comm.valid && rl_param.valid |=> remote_reg == $past(rl_comm.value))
    else $error("link did not win over parameter write");

  AST_LAMPS: assert property (
    stop_lamp == !run_reg && remote_lamp == remote_reg ##0 (stop_lamp || view_reg != mode_arbiter_pkg::VIEW_STOP))
    else $error("lamps disagree with mode");

endmodule

`default_nettype wire

// ---- bench/operator_panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module operator_panel_model (
  // Clock
  input  wire logic      mclk,
  // Contacts: stop/run, remote/local, latch release
  output var logic [2:0] contacts,
  // Keys: up, down, confirm, function
  output var logic [3:0] keys
);
  // Nothing pressed, contacts open
  initial begin
    contacts = 3'h0;
    keys = 4'h0;
  end

  // One-clock stroke, launched just after an edge
  task automatic press(input logic [3:0] m);
    keys = m;
    @(posedge mclk);
    #1;
    keys = 4'h0;
    @(posedge mclk);
    #1;
  endtask

  // Contacts change just after an edge
  task automatic set_contacts(input logic [2:0] c);
    contacts = c;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                        mclk, srst, cfg_load, comm_out_wr, comm_latch_release, manual_mode, local_sp_wr;
  logic [15:0]                 auto_out, preset_out, hi_lim, lo_lim, step, remote_sp, lsp, comm_val, exp_v;
  logic [2:0]                  pid_in;
  logic [3:0]                  alarm_raw, al;
  mode_arbiter_pkg::cfg_t      cfg;
  mode_arbiter_pkg::mode_req_t sr_param, sr_comm, sr_key, rl_param, rl_comm, rl_key;
  wire logic [2:0]             ct;
  wire logic [3:0]             keys, latch;
  wire logic [15:0]            ctl_out, pend, act_sp, loc_sp;
  wire mode_arbiter_pkg::view_t view;
  wire logic                   stop_lamp, remote_lamp, alg;
  wire logic [2:0]             pid_grp;
  int                          n_errors, total_checks;

  operator_panel_model u_panel (.mclk(mclk), .contacts(ct), .keys(keys));

  operating_mode_switch_arbiter u_dut (
    .mclk(mclk), .srst(srst), .cfg_load(cfg_load), .cfg_in(cfg),
    .stop_run_contact(ct[2]), .rem_lcl_contact(ct[1]), .latch_contact(ct[0]),
    .sr_param(sr_param), .sr_comm(sr_comm), .sr_key(sr_key), .rl_param(rl_param), .rl_comm(rl_comm), .rl_key(rl_key),
    .ufkey_press(keys[0]), .key_up(keys[3]), .key_down(keys[2]), .confirm_key(keys[1]),
    .comm_out_wr(comm_out_wr), .comm_out_value(comm_val), .comm_latch_release(comm_latch_release),
    .manual_mode(manual_mode), .auto_out(auto_out), .preset_out(preset_out), .output_high_limit(hi_lim),
    .output_low_limit(lo_lim), .manual_step(step), .remote_sp(remote_sp), .local_sp_wr(local_sp_wr),
    .local_sp_wdata(lsp), .pid_group_in(pid_in), .alarm_raw(alarm_raw), .ctl_out_reg(ctl_out),
    .pending_out(pend), .active_sp_reg(act_sp), .local_sp_reg(loc_sp), .pid_group_reg(pid_grp), .alg_track(alg),
    .view_reg(view), .alarm_latch_reg(latch), .stop_lamp(stop_lamp), .remote_lamp(remote_lamp));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Advance n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic sreq(ref mode_arbiter_pkg::mode_req_t r, input logic v);
    r = '{valid: 1'b1, value: v};
    tick(1);
    r = '{valid: 1'b0, value: 1'b0};
    tick(1);
  endtask

  task automatic pls(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  task automatic chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    chk_val(what, {15'h0, e}, {15'h0, g});
  endtask

  task automatic alarm_pulse();
    al = 4'h1 + 4'($urandom_range(14));
    alarm_raw = al;
    tick(1);
    alarm_raw = 4'h0;
    tick(1);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h3a1b6823));
    n_errors = 0;
    total_checks = 0;
    {srst, cfg_load, comm_out_wr, comm_latch_release, manual_mode, local_sp_wr} = 6'h20;
    {sr_param, sr_comm, sr_key, rl_param, rl_comm, rl_key} = 12'h000;
    {alarm_raw, pid_in, cfg} = '0;
    {hi_lim, lo_lim} = {16'hF000, 16'h1000};
    preset_out = 16'h1100 + 16'($urandom_range(16'hC000));
    pid_in = 3'($urandom);
    auto_out = 16'($urandom);
    remote_sp = 16'($urandom);
    lsp = 16'($urandom);
    step = 16'h0001 + 16'($urandom_range(255));
    comm_val = 16'h1000 + 16'($urandom_range(16'hD000));
    tick(6);
    srst = 1'b0;
    chk_bit("stop_lamp", 1'b1, stop_lamp);
    chk_val("view", 16'(mode_arbiter_pkg::VIEW_STOP), 16'(view));
    chk_bit("alg_track", 1'b1, alg);
    alarm_pulse();
    u_panel.press(4'h1);
    u_panel.set_contacts(3'b001);
    tick(4);
    chk_val("latch", 16'(al), 16'(latch));
    u_panel.set_contacts(3'b000);
    pls(comm_latch_release);
    chk_val("latch", 16'h0, 16'(latch));
    cfg.ufkey_func = mode_arbiter_pkg::UF_LATCH;
    cfg.limiter_en = 1'b1;
    pls(cfg_load);
    alarm_pulse();
    u_panel.press(4'h1);
    tick(1);
    chk_val("latch", 16'h0, 16'(latch));
    pls(local_sp_wr);
    $display("test latch done");
    sreq(sr_comm, 1'b1);
    chk_bit("stop_lamp", 1'b0, stop_lamp);
    chk_val("ctl_out", auto_out, ctl_out);
    chk_bit("alg_track", 1'b0, alg);
    chk_val("view", 16'(mode_arbiter_pkg::VIEW_SP), 16'(view));
    sreq(sr_key, 1'b0);
    chk_val("ctl_out", preset_out, ctl_out);
    manual_mode = 1'b1;
    sreq(sr_param, 1'b1);
    chk_val("ctl_out", preset_out, ctl_out);
    chk_val("view", 16'(mode_arbiter_pkg::VIEW_OUT), 16'(view));
    u_panel.press(4'h8);
    tick(1);
    chk_val("ctl_out", preset_out + step, ctl_out);
    u_panel.press(4'h4);
    u_panel.press(4'h4);
    u_panel.press(4'hC);
    tick(2);
    chk_val("ctl_out", preset_out - step, ctl_out);
    pls(comm_out_wr);
    tick(1);
    chk_val("ctl_out", comm_val, ctl_out);
    $display("test manual direct done");
    cfg.manual_output_method = mode_arbiter_pkg::confirm_key_method;
    pls(cfg_load);
    exp_v = comm_val + step;
    u_panel.press(4'h8);
    chk_val("pending", exp_v, pend);
    tick(1);
    chk_val("ctl_out", comm_val, ctl_out);
    u_panel.press(4'h2);
    tick(1);
    chk_val("ctl_out", exp_v, ctl_out);
    cfg.control_type_onoff = 1'b1;
    hi_lim = exp_v;
    pls(cfg_load);
    u_panel.press(4'h8);
    tick(1);
    chk_val("ctl_out", exp_v, ctl_out);
    cfg.limiter_en = 1'b0;
    pls(cfg_load);
    u_panel.press(4'h8);
    tick(1);
    chk_val("ctl_out", exp_v + step, ctl_out);
    cfg.shutdown_low_setting = 1'b1;
    cfg.current_loop = 1'b1;
    pls(cfg_load);
    comm_val = 16'h0000;
    pls(comm_out_wr);
    tick(1);
    chk_val("ctl_out", 16'h0000, ctl_out);
    sreq(sr_comm, 1'b0);
    u_panel.press(4'h8);
    tick(2);
    chk_val("ctl_out", preset_out, ctl_out);
    $display("test manual confirm done");
    cfg.stop_run_assign = 4'h1;
    pls(cfg_load);
    sreq(sr_comm, 1'b1);
    sreq(sr_key, 1'b1);
    chk_bit("stop_lamp", 1'b1, stop_lamp);
    sreq(sr_param, 1'b1);
    chk_bit("stop_lamp", 1'b0, stop_lamp);
    u_panel.set_contacts(3'b100);
    tick(4);
    chk_bit("stop_lamp", 1'b1, stop_lamp);
    cfg.rem_lcl_assign = 4'h1;
    pls(cfg_load);
    u_panel.set_contacts(3'b010);
    tick(4);
    sreq(rl_comm, 1'b0);
    chk_bit("remote_lamp", 1'b1, remote_lamp);
    chk_val("active_sp", remote_sp, act_sp);
    exp_v = 16'(pid_in);
    pid_in = ~pid_in;
    tick(2);
    chk_val("pid_group", exp_v, 16'(pid_grp));
    u_panel.set_contacts(3'b000);
    tick(4);
    sreq(rl_key, 1'b0);
    chk_val("active_sp", lsp, act_sp);
    cfg.sp_track = 1'b1;
    cfg.rem_lcl_edge = 1'b1;
    pls(cfg_load);
    u_panel.set_contacts(3'b010);
    tick(4);
    chk_bit("remote_lamp", 1'b1, remote_lamp);
    sreq(rl_param, 1'b0);
    chk_bit("remote_lamp", 1'b0, remote_lamp);
    chk_val("local_sp", remote_sp, loc_sp);
    $display("test mode switching done");
    final_report();
  end
endmodule
`default_nettype wire
